// ===== verilog/sirg_pkg.sv
// package for the serial input routing and unit gate block
// assumes a single 250 MHz clock domain and a plain strobe register port
package sirg_pkg;
   localparam int ADDR_W = 32;
   localparam logic [31:0] ROUTE_OFS = 32'h40040473;
   localparam logic [31:0] FILT_OFS = 32'h40040474;
   localparam logic [31:0] PCLK_OFS = 32'h40040475;
   // per-unit control stand-in registers, gated by the unit clock enables
   localparam logic [31:0] UCTL0_OFS = 32'h40040480;
   localparam logic [31:0] UCTL1_OFS = 32'h40040484;
   localparam int ROUTE_IRQ_BIT = 0;
   localparam int ROUTE_TMR_BIT = 1;
   localparam int ROUTE_SS_BIT = 7;
   localparam logic [7:0] ROUTE_MASK = 8'h83;
   localparam int FILT_U0RX_BIT = 0;
   localparam logic [7:0] FILT_MASK = 8'h15;
   localparam int PCLK_U0_BIT = 2;
   localparam int PCLK_U1_BIT = 3;
   localparam logic [7:0] ROUTE_RST = 8'h00;
   localparam logic [7:0] FILT_RST = 8'h00;
   localparam logic [7:0] PCLK_RST = 8'h00;
   localparam logic [7:0] UCTL_RST = 8'h00;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } sirg_bus_t;

   typedef struct packed {
      logic ext_irq_in;
      logic timer_ch3_in;
   } sirg_route_t;
endpackage

// ===== verilog/sirg_rx_filter.sv
// input synchroniser with optional two-sample agreement filter
// assumes clk is the channel operating clock and din is asynchronous
`timescale 1ns/1ps
`default_nettype none
module sirg_rx_filter import sirg_pkg::*; (
   input wire logic clk, // channel operating clock
   input wire logic rst, // async reset, active high
   input wire logic din, // raw pin level
   input wire logic filt_on, // agreement filter enable
   output logic dout // cleaned level
);
   logic s1, s2, s3, next_dout;
   always_comb begin
      next_dout = s2;
      if (filt_on && (s2 != s3)) begin
         next_dout = dout;
      end
   end
   // reset to idle-high, the line level of an idle receive pin
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s1 <= 1'b1;
         s2 <= 1'b1;
         s3 <= 1'b1;
         dout <= 1'b1;
      end else begin
         s1 <= din;
         s2 <= s1;
         s3 <= s2;
         dout <= next_dout;
      end
   end
endmodule // sirg_rx_filter
`default_nettype wire

// ===== verilog/sirg_top.sv
// serial input routing, slave-select gate and serial unit clock gate
// assumes pins are asynchronous and registers are reached over a strobe port
// What this block does
// - Routing bit 0 set sends the receive pin, or idle high while unit 0 is stopped, to external interrupt 0, else its own pin.
// - Routing bit 1 set sends the receive pin, or idle high while unit 0 is stopped, to timer channel 3, else its own pin.
// - The slave-select pin of channel 0 counts only while the honour bit is 1.
// - While honoured and high, slave-select blocks transfers; low lets them run.
// - The routing register is 8 bits, RW, resets to 00H, unused bits read zero.
// - Filter on: synchronise and take a level only when two samples agree; off: only sync.
// - The filter register is 8 bits, resets to 00H, bit 0 is the receive pin, bits 7-5,3,1 zero.
// - Clock-enable bit 2 gates serial unit 0 and bit 3 gates serial unit 1.
// - A stopped unit ignores control writes and reads initial values; routing regs exempt.
// - A stopped unit does no serial work and its pins fall back to port use.
//
// Design decision made here: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module sirg_top import sirg_pkg::*; (
   input wire logic clk, // 250 MHz system clock
   input wire logic rst, // async reset, active high
   input wire logic [ADDR_W-1:0] addr, // register address
   input wire logic [7:0] wdata, // write data
   input wire logic wr, // write strobe
   input wire logic rd, // read strobe
   output logic [7:0] rdata, // read data, cycle after rd
   input wire logic uart0_receive_pin, // receive pin
   input wire logic external_irq_zero, // dedicated interrupt pin
   input wire logic timer_ch3_input_pin, // timer capture pin
   input wire logic slave_select_pin, // slave-select pin, active low
   output sirg_route_t route_out, // routed interrupt and timer inputs
   output logic uart0_rx_clean, // filtered receive level to unit 0
   output logic transfer_allow, // channel 0 may shift on serial clocks
   output logic unit0_clk_en, // clock gate enable, serial unit 0
   output logic unit1_clk_en, // clock gate enable, serial unit 1
   output logic unit0_pins_port, // unit 0 pins revert to port use
   output logic unit1_pins_port, // unit 1 pins revert to port use
   output logic [7:0] unit0_ctrl, // unit 0 control value
   output logic [7:0] unit1_ctrl // unit 1 control value
);
   sirg_bus_t bus;
   logic [7:0] input_route_ctrl, next_route;
   logic [7:0] rx_filter_enable, next_filt;
   logic [7:0] peripheral_clock_enable, next_pclk;
   logic [7:0] uctl0, uctl1, next_uctl0, next_uctl1;
   logic [7:0] next_rdata;
   logic [2:0] pin_s1, pin_s2;
   sirg_route_t next_route_out;
   logic next_allow;
   logic rx_filt, next_rx_clean;

   assign bus = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [31:0] ofs);
      hit = (a == ofs);
   endfunction

   // register writes
   always_comb begin
      next_route = input_route_ctrl;
      next_filt = rx_filter_enable;
      next_pclk = peripheral_clock_enable;
      next_uctl0 = uctl0;
      next_uctl1 = uctl1;
      if (bus.wr) begin
         if (hit(bus.addr, ROUTE_OFS)) begin
            next_route = bus.wdata & ROUTE_MASK;
         end
         if (hit(bus.addr, FILT_OFS)) begin
            next_filt = bus.wdata & FILT_MASK;
         end
         if (hit(bus.addr, PCLK_OFS)) begin
            next_pclk = bus.wdata;
         end
         if (hit(bus.addr, UCTL0_OFS) && peripheral_clock_enable[PCLK_U0_BIT]) begin
            next_uctl0 = bus.wdata;
         end
         if (hit(bus.addr, UCTL1_OFS) && peripheral_clock_enable[PCLK_U1_BIT]) begin
            next_uctl1 = bus.wdata;
         end
      end
   end

   // read path; a stopped unit shows its reset value, not its stored one
   always_comb begin
      next_rdata = 8'h00;
      if (bus.rd) begin
         if (hit(bus.addr, ROUTE_OFS)) begin
            next_rdata = input_route_ctrl;
         end else if (hit(bus.addr, FILT_OFS)) begin
            next_rdata = rx_filter_enable;
         end else if (hit(bus.addr, PCLK_OFS)) begin
            next_rdata = peripheral_clock_enable;
         end else if (hit(bus.addr, UCTL0_OFS)) begin
            next_rdata = peripheral_clock_enable[PCLK_U0_BIT] ? uctl0 : UCTL_RST;
         end else if (hit(bus.addr, UCTL1_OFS)) begin
            next_rdata = peripheral_clock_enable[PCLK_U1_BIT] ? uctl1 : UCTL_RST;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         input_route_ctrl <= ROUTE_RST;
         rx_filter_enable <= FILT_RST;
         peripheral_clock_enable <= PCLK_RST;
         uctl0 <= UCTL_RST;
         uctl1 <= UCTL_RST;
         rdata <= 8'h00;
      end else begin
         input_route_ctrl <= next_route;
         rx_filter_enable <= next_filt;
         peripheral_clock_enable <= next_pclk;
         uctl0 <= next_uctl0;
         uctl1 <= next_uctl1;
         rdata <= next_rdata;
      end
   end

   // pin synchronisers for interrupt, timer and slave-select pins
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pin_s1 <= 3'h7;
         pin_s2 <= 3'h7;
      end else begin
         pin_s1 <= {slave_select_pin, timer_ch3_input_pin, external_irq_zero};
         pin_s2 <= pin_s1;
      end
   end

   // the raw pin goes straight into the synchroniser; gating it first would put
   // logic ahead of the first flop of an asynchronous input
   sirg_rx_filter u_rx_filter (
      .clk(clk),
      .rst(rst),
      .din(uart0_receive_pin),
      .filt_on(rx_filter_enable[FILT_U0RX_BIT]),
      .dout(rx_filt)
   );

   // muxing registered sources, then registering the result, keeps the
   // routed lines free of select-change glitches
   always_comb begin
      // a stopped unit 0 has no receive path, so it sees an idle line
      next_rx_clean = peripheral_clock_enable[PCLK_U0_BIT] ? rx_filt : 1'b1;
      next_route_out.ext_irq_in = input_route_ctrl[ROUTE_IRQ_BIT] ? uart0_rx_clean
                                                                  : pin_s2[0];
      next_route_out.timer_ch3_in = input_route_ctrl[ROUTE_TMR_BIT] ? uart0_rx_clean
                                                                    : pin_s2[1];
      next_allow = peripheral_clock_enable[PCLK_U0_BIT];
      if (input_route_ctrl[ROUTE_SS_BIT] && pin_s2[2]) begin
         next_allow = 1'b0;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         route_out <= '{ext_irq_in: 1'b1, timer_ch3_in: 1'b1};
         transfer_allow <= 1'b0;
         uart0_rx_clean <= 1'b1;
      end else begin
         route_out <= next_route_out;
         transfer_allow <= next_allow;
         uart0_rx_clean <= next_rx_clean;
      end
   end

   assign unit0_clk_en = peripheral_clock_enable[PCLK_U0_BIT];
   assign unit1_clk_en = peripheral_clock_enable[PCLK_U1_BIT];
   assign unit0_pins_port = ~peripheral_clock_enable[PCLK_U0_BIT];
   assign unit1_pins_port = ~peripheral_clock_enable[PCLK_U1_BIT];
   assign unit0_ctrl = peripheral_clock_enable[PCLK_U0_BIT] ? uctl0 : UCTL_RST;
   assign unit1_ctrl = peripheral_clock_enable[PCLK_U1_BIT] ? uctl1 : UCTL_RST;
endmodule // sirg_top
`default_nettype wire

// ===== dv/sirg_properties.sv
// concurrent checks for the serial input routing and unit gate
// assumes binding to sirg_top, one clock domain, async active-high reset
`timescale 1ns/1ps
`default_nettype none
module sirg_properties import sirg_pkg::*; (
   input wire logic clk, // system clock
   input wire logic rst, // async reset
   input wire logic [ADDR_W-1:0] addr, // register address
   input wire logic [7:0] wdata, // write data
   input wire logic wr, // write strobe
   input wire logic rd, // read strobe
   input wire logic [7:0] rdata, // read data
   input wire logic external_irq_zero, // interrupt pin
   input wire logic timer_ch3_input_pin, // timer pin
   input wire logic slave_select_pin, // slave-select pin
   input wire sirg_route_t route_out, // routed levels
   input wire logic uart0_rx_clean, // filtered receive level
   input wire logic transfer_allow, // channel 0 may shift
   input wire logic unit0_clk_en, // unit 0 clock gate
   input wire logic unit1_clk_en, // unit 1 clock gate
   input wire logic unit0_pins_port, // unit 0 pins to port
   input wire logic [7:0] unit0_ctrl // unit 0 control value
);
   // shadow copies so path checks know which source is selected
   logic [7:0] route_q, next_route_q, pclk_q, next_pclk_q;
   always_comb begin
      next_route_q = route_q;
      next_pclk_q = pclk_q;
      if (wr && addr == ROUTE_OFS) next_route_q = wdata & ROUTE_MASK;
      if (wr && addr == PCLK_OFS) next_pclk_q = wdata;
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         route_q <= 8'h00;
         pclk_q <= 8'h00;
      end else begin
         route_q <= next_route_q;
         pclk_q <= next_pclk_q;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_route_wr; wr && addr == ROUTE_OFS; endsequence
   sequence s_route_rd; rd && !wr && addr == ROUTE_OFS; endsequence
   AST_ROUTE_RB: assert property (s_route_wr ##1 s_route_rd |=>
      rdata == ($past(wdata, 2) & ROUTE_MASK)) else $error("route readback wrong");
   AST_RD_IDLE: assert property (!rd |=> rdata == 8'h00) else $error("rdata not idle");
   AST_CLKEN: assert property (unit0_clk_en == pclk_q[2] && unit1_clk_en == pclk_q[3])
      else $error("unit clock enable wrong");
   AST_PINS: assert property (unit0_pins_port == !unit0_clk_en) else $error("pin use wrong");
   AST_STOPPED: assert property (!unit0_clk_en |-> unit0_ctrl == 8'h00)
      else $error("stopped unit shows control");
   AST_IRQ_OWN: assert property ((!route_q[0] && $stable(external_irq_zero))[*4] |->
      route_out.ext_irq_in == external_irq_zero) else $error("irq own pin lost");
   AST_IRQ_RX: assert property ((route_q[0] && $stable(uart0_rx_clean))[*3] |->
      route_out.ext_irq_in == uart0_rx_clean) else $error("irq not from receive");
   AST_TMR_OWN: assert property ((!route_q[1] && $stable(timer_ch3_input_pin))[*4] |->
      route_out.timer_ch3_in == timer_ch3_input_pin) else $error("timer own pin lost");
   AST_SS_BLOCK: assert property ((route_q[7] && slave_select_pin)[*4] |-> !transfer_allow)
      else $error("transfer while deselected");
   AST_SS_IGNORE: assert property ((!route_q[7] && unit0_clk_en)[*4] |-> transfer_allow)
      else $error("ignored select blocks");
endmodule // sirg_properties
`default_nettype wire

// ===== dv/test_sirg_top.sv
// self-checking bench for the serial input routing and unit gate
// assumes sirg_pkg, sirg_top and sirg_properties are compiled first
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin failures++; \
   $display("MISMATCH %s exp %h got %h", n, e, g); end end
module test_sirg_top import sirg_pkg::*;;
   logic clk, rst, wr, rd, rx, irq, tmr, ss, rxc, ta, e0, e1, p0, p1;
   logic rd_seen = 1'b0;
   logic [ADDR_W-1:0] addr;
   logic [7:0] wdata, rdata, u0c, u1c, exp_r, v;
   logic [7:0] expq[$];
   logic [2:0] pins;
   logic [31:0] ofs [6] = '{ROUTE_OFS, FILT_OFS, PCLK_OFS, UCTL0_OFS, UCTL1_OFS, 32'h40040476};
   sirg_route_t ro;
   int failures = 0;
   int tests_run = 0;
   sirg_top i_dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .uart0_receive_pin(rx), .external_irq_zero(irq), .timer_ch3_input_pin(tmr),
      .slave_select_pin(ss), .route_out(ro), .uart0_rx_clean(rxc), .transfer_allow(ta),
      .unit0_clk_en(e0), .unit1_clk_en(e1), .unit0_pins_port(p0), .unit1_pins_port(p1),
      .unit0_ctrl(u0c), .unit1_ctrl(u1c));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic op(input logic w, r, input logic [31:0] a, input logic [7:0] d, e);
      @(posedge clk);
      {wr, rd} <= {w, r};
      addr <= a;
      wdata <= d;
      if (r) expq.push_back(e);
   endtask
   task automatic wreg(input logic [31:0] a, input logic [7:0] d);
      op(1'b1, 1'b0, a, d, 8'h00);
   endtask
   task automatic rreg(input logic [31:0] a, input logic [7:0] e);
      op(1'b0, 1'b1, a, 8'h00, e);
   endtask
   task automatic idle(input int n);
      op(1'b0, 1'b0, 32'h0, 8'h00, 8'h00);
      repeat (n - 1) @(posedge clk);
      #1;
   endtask
   task automatic stop_test;
      if (failures == 0 && tests_run > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // read results land one cycle after the strobe and stand only there
   always @(posedge clk) begin
      if (rd_seen) begin
         exp_r = expq.pop_front();
         `CHK("rdata", exp_r, rdata)
      end
      rd_seen <= rd;
   end
   initial begin
      repeat (2000) @(posedge clk);
      failures++;
      stop_test;
   end
   initial begin
      void'($urandom(32'h677B));
      {rst, wr, rd, rx, irq, tmr, ss} = 7'b1001001;
      addr = '0;
      wdata = '0;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      foreach (ofs[i]) rreg(ofs[i], 8'h00);
      wreg(ROUTE_OFS, 8'hFF);
      rreg(ROUTE_OFS, 8'h83);
      wreg(FILT_OFS, 8'hFF);
      rreg(FILT_OFS, 8'h15);
      v = 8'($urandom);
      wreg(UCTL0_OFS, v);
      rreg(UCTL0_OFS, 8'h00);
      wreg(PCLK_OFS, 8'h0C);
      wreg(UCTL0_OFS, v);
      wreg(UCTL1_OFS, ~v);
      rreg(UCTL0_OFS, v);
      wreg(PCLK_OFS, 8'h04);
      rreg(UCTL1_OFS, 8'h00);
      idle(2);
      `CHK("clk_en", 4'b1001, {e0, e1, p0, p1})
      `CHK("unit_ctrl", {v, 8'h00}, {u0c, u1c})
      for (int r = 0; r < 4; r++) begin
         wreg(ROUTE_OFS, 8'(r));
         pins = 3'($urandom);
         {rx, irq, tmr} <= pins;
         idle(8);
         `CHK("route", {r[0] ? pins[2] : pins[1], r[1] ? pins[2] : pins[0]}, ro)
      end
      `CHK("allow", 1'b1, ta)
      wreg(ROUTE_OFS, 8'h80);
      idle(6);
      `CHK("allow", 1'b0, ta)
      op(1'b0, 1'b0, 32'h0, 8'h00, 8'h00);
      ss <= 1'b0;
      idle(6);
      `CHK("allow", 1'b1, ta)
      wreg(PCLK_OFS, 8'h00);
      idle(6);
      `CHK("stopped", 2'b01, {ta, p0})
      wreg(PCLK_OFS, 8'h04);
      wreg(FILT_OFS, 8'h01);
      rx <= 1'b1;
      idle(6);
      rx <= 1'b0;
      idle(1);
      rx <= 1'b1;
      // a single-sample dip must never reach the unit
      repeat (6) begin
         idle(1);
         `CHK("rx_clean", 1'b1, rxc)
      end
      wreg(FILT_OFS, 8'h00);
      rx <= 1'b0;
      idle(6);
      `CHK("rx_clean", 1'b0, rxc)
      stop_test;
   end
endmodule // test_sirg_top
bind sirg_top sirg_properties i_prop (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
   .wr(wr), .rd(rd), .rdata(rdata), .external_irq_zero(external_irq_zero),
   .timer_ch3_input_pin(timer_ch3_input_pin), .slave_select_pin(slave_select_pin),
   .route_out(route_out), .uart0_rx_clean(uart0_rx_clean), .transfer_allow(transfer_allow),
   .unit0_clk_en(unit0_clk_en), .unit1_clk_en(unit1_clk_en),
   .unit0_pins_port(unit0_pins_port), .unit0_ctrl(unit0_ctrl));
`default_nettype wire
